// file: rms_bdc_bit.sv
// single bit time engine on the shared debug pin
`timescale 1ns/1ns
module rms_bdc_bit (
  // clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // control
  input  wire logic enable,
  input  wire logic start,
  input  wire logic tx_bit,
  output logic      busy,
  output logic      done,
  output logic      rx_bit,
  // debug pin
  input  wire logic pin_in,
  output logic      pin_out,
  output logic      pin_oe_n
);
  import rms_pkg::*;

  logic [4:0] cnt_reg;
  logic [4:0] low_len_reg;

  // debug clock equals bus clock, so one count per bus edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy        <= 1'b0;
      done        <= 1'b0;
      cnt_reg     <= 5'h00;
      low_len_reg <= 5'h00;
      rx_bit      <= 1'b0;
    end else begin
      done <= 1'b0;
      if (!enable) begin
        busy    <= 1'b0;
        cnt_reg <= 5'h00;
      end else if (!busy) begin
        if (start) begin
          busy        <= 1'b1;
          cnt_reg     <= 5'h00;
          low_len_reg <= tx_bit ? 5'(BDC_ONE_LOW) : 5'(BDC_ZERO_LOW);
        end
      end else begin
        if (cnt_reg == 5'(BDC_SAMPLE_AT))
          rx_bit <= pin_in;
        if (cnt_reg == 5'(BDC_BIT_CYCLES - 1)) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          cnt_reg <= cnt_reg + 5'h01;
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b1;
    end else if (enable && start && !busy) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b0;
    end else if (enable && busy && cnt_reg + 5'h01 < low_len_reg) begin
      pin_out  <= 1'b0;
      pin_oe_n <= 1'b0;
    end else if (enable && busy && cnt_reg + 5'h01 == low_len_reg) begin
      // one cycle of active high speeds the edge, then pull-up holds
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b0;
    end else begin
      pin_out  <= 1'b1;
      pin_oe_n <= 1'b1;
    end
  end

endmodule // rms_bdc_bit

// file: rms_gpio_port.sv
// general-purpose pin control with peripheral override
`timescale 1ns/1ns
module rms_gpio_port (
  // clock and reset
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  // configuration
  input  rms_pkg::rms_gpio_cfg_t     cfg,
  // peripheral override
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_en,
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_oe,
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_out,
  // pads
  input  wire logic [rms_pkg::GPIO_W-1:0] pin_in,
  output rms_pkg::rms_gpio_pad_t     pad,
  output logic [rms_pkg::GPIO_W-1:0] read_data
);
  import rms_pkg::*;

  genvar i;
  generate
    for (i = 0; i < GPIO_W; i++) begin : g_pin
      always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          pad.out[i]      <= 1'b0;
          pad.oe_n[i]     <= 1'b1;
          pad.drive_hi[i] <= 1'b0;
          pad.slew_en[i]  <= 1'b0;
          pad.pull_en[i]  <= 1'b0;
          read_data[i]    <= 1'b0;
        end else begin
          // peripheral owns the buffer enable when it claims the pin
          pad.out[i]      <= periph_en[i] ? periph_out[i] : cfg.data[i];
          pad.oe_n[i]     <= periph_en[i] ? ~periph_oe[i] : ~cfg.dir[i];
          pad.drive_hi[i] <= cfg.drive[i];
          pad.slew_en[i]  <= cfg.slew[i];
          // pull-up only meaningful while the pin is an input
          pad.pull_en[i]  <= cfg.pull[i] & ~cfg.dir[i];
          read_data[i]    <= cfg.dir[i] ? cfg.data[i] : pin_in[i];
        end
      end
    end
  endgenerate

endmodule // rms_gpio_port

// file: rms_pkg.sv
// constants, types and register map of the reset and mode select block
package rms_pkg;

  // ----------------------------------------------------------------------
  // sizes and timing
  // ----------------------------------------------------------------------
  localparam int GPIO_W           = 8;
  localparam int CAUSE_W          = 7;
  localparam int IRQ_W            = 3;
  localparam int RST_DRIVE_CYCLES = 34;
  localparam int BDC_BIT_CYCLES   = 16;
  localparam int BDC_ONE_LOW      = 4;
  localparam int BDC_ZERO_LOW     = 13;
  localparam int BDC_SAMPLE_AT    = 10;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [7:0] OFS_CAUSE     = 8'h00;
  localparam logic [7:0] OFS_CTRL      = 8'h04;
  localparam logic [7:0] OFS_MODE      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h10;
  localparam logic [7:0] OFS_GP_DATA   = 8'h14;
  localparam logic [7:0] OFS_GP_DIR    = 8'h18;
  localparam logic [7:0] OFS_GP_DRIVE  = 8'h1C;
  localparam logic [7:0] OFS_GP_SLEW   = 8'h20;
  localparam logic [7:0] OFS_GP_PULL   = 8'h24;
  localparam logic [7:0] OFS_GP_READ   = 8'h28;
  localparam logic [7:0] OFS_BDC_TX    = 8'h2C;
  localparam logic [7:0] OFS_BDC_STAT  = 8'h30;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CAUSE_POR  = 0;
  localparam int CAUSE_PIN  = 1;
  localparam int CAUSE_SW   = 2;
  localparam int CAUSE_INT0 = 3;   // cop, lvd, illegal op, illegal addr
  localparam int CTRL_SWRST = 0;
  localparam int CTRL_CLKEX = 1;
  localparam int MODE_DEBUG = 0;
  localparam int MODE_CLKEX = 1;
  localparam int IRQ_DONE   = 0;
  localparam int IRQ_BDC    = 1;
  localparam int IRQ_HOLD   = 2;
  localparam int BDC_BUSY   = 0;
  localparam int BDC_RX     = 1;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic [CAUSE_W-1:0] CAUSE_RST = 7'h01;
  localparam logic [IRQ_W-1:0]   MASK_RST  = 3'h0;
  localparam logic [GPIO_W-1:0]  GPIO_RST  = 8'h00;

  // ----------------------------------------------------------------------
  // types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    RMS_ST_DRIVE,
    RMS_ST_RELEASE,
    RMS_ST_RUN
  } rms_state_t;

  typedef struct packed {
    logic [GPIO_W-1:0] data;
    logic [GPIO_W-1:0] dir;
    logic [GPIO_W-1:0] drive;
    logic [GPIO_W-1:0] slew;
    logic [GPIO_W-1:0] pull;
  } rms_gpio_cfg_t;

  typedef struct packed {
    logic [GPIO_W-1:0] out;
    logic [GPIO_W-1:0] oe_n;
    logic [GPIO_W-1:0] drive_hi;
    logic [GPIO_W-1:0] slew_en;
    logic [GPIO_W-1:0] pull_en;
  } rms_gpio_pad_t;

endpackage

// file: rms_pod.sv
// partner model: reset switch and debug pod, pins with pull-ups
`timescale 1ns/1ns
module rms_pod (
  // commands from the bench
  input  wire logic hold_rst,
  input  wire logic hold_ms,
  // device side of the pins
  input  wire logic rst_out,
  input  wire logic rst_oe_n,
  input  wire logic ms_out,
  input  wire logic ms_oe_n,
  // resolved pin levels
  output logic      rst_pin,
  output logic      ms_pin
);
  // pull-up holds a pin high only when nobody drives it
  assign rst_pin = !rst_oe_n ? rst_out : !hold_rst;
  assign ms_pin  = !ms_oe_n ? ms_out : !hold_ms;
endmodule // rms_pod

// file: rms_reset_mode.sv
// reset sequencer, mode select, clock default and register file
//
// Chosen here: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ns
module rms_reset_mode (
  // ahb-lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // reset pin
  input  wire logic        rst_pin_in,
  output logic             rst_pin_out,
  output logic             rst_pin_oe_n,
  // internal reset sources: cop, lvd, illegal op, illegal addr
  input  wire logic [3:0]  int_rst_req,
  // system outputs
  output logic             core_reset_n,
  output logic             debug_mode,
  output logic             clk_src_ext,
  output logic             irq,
  // debug / mode select pin
  input  wire logic        debug_mode_select_pin_in,
  output logic             debug_mode_select_pin_out,
  output logic             debug_mode_select_pin_oe_n,
  // peripheral override of general-purpose pins
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_en,
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_oe,
  input  wire logic [rms_pkg::GPIO_W-1:0] periph_out,
  // general-purpose pins
  input  wire logic [rms_pkg::GPIO_W-1:0] gpio_in,
  output rms_pkg::rms_gpio_pad_t          gpio_pad
);
  import rms_pkg::*;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  rms_state_t          state_reg;
  logic [5:0]          cnt_reg;
  logic                hold_seen_reg;
  logic                sw_rst_reg;
  logic [CAUSE_W-1:0]  cause_reg;
  logic                clk_ext_reg;
  logic [IRQ_W-1:0]    irq_stat_reg;
  logic [IRQ_W-1:0]    irq_stat_next;
  logic [IRQ_W-1:0]    irq_mask_reg;
  logic [IRQ_W-1:0]    irq_ev;
  rms_gpio_cfg_t       cfg_reg;
  logic                wr_pend_reg;
  logic [7:0]          wr_addr_reg;
  logic                bdc_start_reg;
  logic                bdc_tx_reg;
  logic                bdc_busy;
  logic                bdc_done;
  logic                bdc_rx;
  logic [GPIO_W-1:0]   gpio_read;
  logic                in_run;
  logic                rst_request;
  logic [CAUSE_W-1:0]  new_cause;
  logic                addr_ph;
  logic                wr_ctrl;
  logic                release_done;
  logic [31:0]         rd_mux;

  assign in_run  = (state_reg == RMS_ST_RUN);
  assign addr_ph = hsel & htrans[1] & hready;
  assign wr_ctrl = wr_pend_reg & (wr_addr_reg == OFS_CTRL);
  assign release_done = (state_reg == RMS_ST_RELEASE) & rst_pin_in;

  // ----------------------------------------------------------------------
  // reset request decode
  // ----------------------------------------------------------------------
  always_comb begin
    new_cause = '0;
    new_cause[CAUSE_PIN] = ~rst_pin_in;
    new_cause[CAUSE_SW]  = sw_rst_reg;
    new_cause[CAUSE_INT0 +: 4] = int_rst_req;
    rst_request = |new_cause;
  end

  // ----------------------------------------------------------------------
  // reset sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= RMS_ST_DRIVE;
      cnt_reg   <= 6'h00;
    end else begin
      case (state_reg)
        RMS_ST_DRIVE: begin
          if (cnt_reg == 6'(RST_DRIVE_CYCLES - 1)) begin
            state_reg <= RMS_ST_RELEASE;
            cnt_reg   <= 6'h00;
          end else begin
            cnt_reg <= cnt_reg + 6'h01;
          end
        end
        RMS_ST_RELEASE: begin
          // an outside party still holding the pin low extends reset
          if (rst_pin_in)
            state_reg <= RMS_ST_RUN;
        end
        RMS_ST_RUN: begin
          if (rst_request) begin
            state_reg <= RMS_ST_DRIVE;
            cnt_reg   <= 6'h00;
          end
        end
        default: begin
          state_reg <= RMS_ST_DRIVE;
          cnt_reg   <= 6'h00;
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hold_seen_reg <= 1'b0;
    end else if (state_reg == RMS_ST_RELEASE && !rst_pin_in) begin
      hold_seen_reg <= 1'b1;
    end else if (in_run) begin
      hold_seen_reg <= 1'b0;
    end
  end

  // cause is replaced by the new cause at each reset request; only power-on loads CAUSE_RST
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cause_reg <= CAUSE_RST;
    end else if (in_run && rst_request) begin
      cause_reg <= new_cause;
    end
  end

  // ----------------------------------------------------------------------
  // pin and system outputs
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rst_pin_out  <= 1'b0;
      rst_pin_oe_n <= 1'b0;
      core_reset_n <= 1'b0;
    end else begin
      rst_pin_out  <= 1'b0;
      rst_pin_oe_n <= ~((state_reg == RMS_ST_DRIVE &&
                         cnt_reg != 6'(RST_DRIVE_CYCLES - 1)) ||
                        (in_run && rst_request));
      core_reset_n <= (in_run && !rst_request) || release_done;
    end
  end

  // mode pin read only on the release edge of reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      debug_mode <= 1'b0;
    end else if (release_done) begin
      debug_mode <= ~debug_mode_select_pin_in;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_ext_reg <= 1'b0;
      clk_src_ext <= 1'b0;
    end else begin
      if (!in_run)
        clk_ext_reg <= 1'b0;
      else if (wr_ctrl)
        clk_ext_reg <= hwdata[CTRL_CLKEX];
      clk_src_ext <= clk_ext_reg & in_run;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sw_rst_reg <= 1'b0;
    end else begin
      sw_rst_reg <= wr_ctrl & hwdata[CTRL_SWRST] & in_run;
    end
  end

  // ----------------------------------------------------------------------
  // interrupts
  // ----------------------------------------------------------------------
  always_comb begin
    irq_ev = '0;
    irq_ev[IRQ_DONE] = release_done;
    irq_ev[IRQ_BDC]  = bdc_done;
    irq_ev[IRQ_HOLD] = (state_reg == RMS_ST_RELEASE) & ~rst_pin_in &
                       ~hold_seen_reg;
    irq_stat_next = irq_stat_reg;
    if (wr_pend_reg && wr_addr_reg == OFS_IRQ_STAT)
      irq_stat_next = irq_stat_next & ~hwdata[IRQ_W-1:0];
    // a new event wins over a clear in the same cycle
    irq_stat_next = irq_stat_next | irq_ev;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_stat_reg <= '0;
      irq_mask_reg <= MASK_RST;
      irq          <= 1'b0;
    end else begin
      irq_stat_reg <= irq_stat_next;
      if (wr_pend_reg && wr_addr_reg == OFS_IRQ_MASK)
        irq_mask_reg <= hwdata[IRQ_W-1:0];
      irq <= |(irq_stat_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // general-purpose pin configuration
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_reg <= '0;
    end else if (!in_run) begin
      cfg_reg <= '0;
    end else if (wr_pend_reg) begin
      case (wr_addr_reg)
        OFS_GP_DATA:  cfg_reg.data  <= hwdata[GPIO_W-1:0];
        OFS_GP_DIR:   cfg_reg.dir   <= hwdata[GPIO_W-1:0];
        OFS_GP_DRIVE: cfg_reg.drive <= hwdata[GPIO_W-1:0];
        OFS_GP_SLEW:  cfg_reg.slew  <= hwdata[GPIO_W-1:0];
        OFS_GP_PULL:  cfg_reg.pull  <= hwdata[GPIO_W-1:0];
        default:      cfg_reg <= cfg_reg;
      endcase
    end
  end

  rms_gpio_port u_gpio (
    .hclk       (hclk),
    .hresetn    (hresetn),
    .cfg        (cfg_reg),
    .periph_en  (periph_en & {GPIO_W{in_run}}),
    .periph_oe  (periph_oe),
    .periph_out (periph_out),
    .pin_in     (gpio_in),
    .pad        (gpio_pad),
    .read_data  (gpio_read)
  );

  // ----------------------------------------------------------------------
  // background debug bit engine
  // ----------------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bdc_start_reg <= 1'b0;
      bdc_tx_reg    <= 1'b0;
    end else begin
      bdc_start_reg <= wr_pend_reg & (wr_addr_reg == OFS_BDC_TX) &
                       in_run & ~bdc_busy;
      if (wr_pend_reg && wr_addr_reg == OFS_BDC_TX)
        bdc_tx_reg <= hwdata[0];
    end
  end

  // pin only talks debug once reset has risen
  rms_bdc_bit u_bdc (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .enable   (in_run & ~rst_request),
    .start    (bdc_start_reg),
    .tx_bit   (bdc_tx_reg),
    .busy     (bdc_busy),
    .done     (bdc_done),
    .rx_bit   (bdc_rx),
    .pin_in   (debug_mode_select_pin_in),
    .pin_out  (debug_mode_select_pin_out),
    .pin_oe_n (debug_mode_select_pin_oe_n)
  );

  // ----------------------------------------------------------------------
  // ahb-lite slave
  // ----------------------------------------------------------------------
  always_comb begin
    rd_mux = 32'h0000_0000;
    case (haddr[7:0])
      OFS_CAUSE:    rd_mux[CAUSE_W-1:0] = cause_reg;
      OFS_CTRL:     rd_mux[CTRL_CLKEX]  = clk_ext_reg;
      OFS_MODE: begin
        rd_mux[MODE_DEBUG] = debug_mode;
        rd_mux[MODE_CLKEX] = clk_src_ext;
      end
      OFS_IRQ_STAT: rd_mux[IRQ_W-1:0]  = irq_stat_reg;
      OFS_IRQ_MASK: rd_mux[IRQ_W-1:0]  = irq_mask_reg;
      OFS_GP_DATA:  rd_mux[GPIO_W-1:0] = cfg_reg.data;
      OFS_GP_DIR:   rd_mux[GPIO_W-1:0] = cfg_reg.dir;
      OFS_GP_DRIVE: rd_mux[GPIO_W-1:0] = cfg_reg.drive;
      OFS_GP_SLEW:  rd_mux[GPIO_W-1:0] = cfg_reg.slew;
      OFS_GP_PULL:  rd_mux[GPIO_W-1:0] = cfg_reg.pull;
      OFS_GP_READ:  rd_mux[GPIO_W-1:0] = gpio_read;
      OFS_BDC_TX:   rd_mux[0]          = bdc_tx_reg;
      OFS_BDC_STAT: begin
        rd_mux[BDC_BUSY] = bdc_busy | bdc_start_reg;
        rd_mux[BDC_RX]   = bdc_rx;
      end
      default:      rd_mux = 32'h0000_0000;
    endcase
    if (haddr[31:8] != 24'h00_0000)
      rd_mux = 32'h0000_0000;
  end

  // zero wait; read data captured at the address phase edge
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      hrdata      <= 32'h0000_0000;
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
    end else begin
      hreadyout   <= 1'b1;
      hresp       <= 1'b0;
      wr_pend_reg <= addr_ph & hwrite & (hsize == 3'h2) &
                     (haddr[31:8] == 24'h00_0000);
      wr_addr_reg <= haddr[7:0];
      if (addr_ph && !hwrite)
        hrdata <= rd_mux;
    end
  end

endmodule // rms_reset_mode

// file: rms_reset_mode_assertions.sv
// checker for the reset and mode select block, bound to its top
`timescale 1ns/1ns
module rms_reset_mode_checker (
  // clock and reset
  input wire logic                   hclk,
  input wire logic                   hresetn,
  // reset pin and system outputs
  input wire logic                   rst_pin_in,
  input wire logic                   rst_pin_oe_n,
  input wire logic                   core_reset_n,
  input wire logic                   debug_mode,
  input wire logic                   clk_src_ext,
  // debug pin and pads
  input wire logic                   debug_mode_select_pin_in,
  input wire logic                   debug_mode_select_pin_out,
  input wire logic                   debug_mode_select_pin_oe_n,
  input rms_pkg::rms_gpio_pad_t      gpio_pad
);
  import rms_pkg::*;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // length of the current low drive on the reset pin
  logic [7:0] low_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) low_cnt <= 8'h00;
    else if (rst_pin_oe_n) low_cnt <= 8'h00;
    else low_cnt <= low_cnt + 8'h01;
  end

  AST_DRIVE_LEN: assert property (
    $rose(rst_pin_oe_n) |-> low_cnt inside {[8'h21:8'h24]})
    else $error("reset pin low drive has the wrong length");
  AST_EXT_REQ: assert property (
    core_reset_n && !rst_pin_in |=> !rst_pin_oe_n && !core_reset_n)
    else $error("external low on reset pin not taken as reset");
  AST_HOLD_EXT: assert property (
    !core_reset_n && rst_pin_oe_n && !rst_pin_in |=> !core_reset_n)
    else $error("reset left while pin still held low");
  AST_MODE_LOAD: assert property (
    $rose(core_reset_n) |-> debug_mode == !$past(debug_mode_select_pin_in))
    else $error("mode not taken from pin at reset release");
  AST_CLK_INT: assert property (
    !core_reset_n |=> !clk_src_ext)
    else $error("external clock selected in reset");
  AST_GPIO_IN: assert property (
    $rose(core_reset_n) |-> (&gpio_pad.oe_n) && gpio_pad.pull_en == 8'h00)
    else $error("pins not plain inputs after reset");
  AST_MS_INPUT: assert property (
    !core_reset_n |-> debug_mode_select_pin_oe_n)
    else $error("mode select pin driven during reset");
  AST_SPEEDUP: assert property (
    $rose(debug_mode_select_pin_oe_n) |-> $past(debug_mode_select_pin_out))
    else $error("debug pin released without high pulse");

  COV_DEBUG: cover property ($rose(core_reset_n) && debug_mode);
  COV_BIT: cover property ($fell(debug_mode_select_pin_oe_n));
  COV_HOLD: cover property (!core_reset_n && rst_pin_oe_n && !rst_pin_in);
endmodule // rms_reset_mode_checker

bind rms_reset_mode rms_reset_mode_checker i_chk (.*);

// file: tb.sv
// self-checking bench for the reset and mode select block
`timescale 1ns/1ns
module tb;
  import rms_pkg::*;
  logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0]  htrans = 2'h0;
  logic        hreadyout, hresp, rst_pin, rst_out, rst_oe_n, core_reset_n;
  logic        debug_mode, clk_src_ext, irq, ms_pin, ms_out, ms_oe_n;
  logic        hold_rst = 1'b0, hold_ms = 1'b0;
  logic [3:0]  int_rst_req = 4'h0;
  logic [7:0]  p_en = 8'h00, p_oe = 8'h00, p_out = 8'h00, pins = 8'h3C;
  rms_gpio_pad_t gpio_pad;
  int          failures = 0, compares = 0, n;

  always #5 hclk = ~hclk;

  rms_reset_mode i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .rst_pin_in(rst_pin),
    .rst_pin_out(rst_out), .rst_pin_oe_n(rst_oe_n),
    .int_rst_req(int_rst_req), .core_reset_n(core_reset_n),
    .debug_mode(debug_mode), .clk_src_ext(clk_src_ext), .irq(irq),
    .debug_mode_select_pin_in(ms_pin), .debug_mode_select_pin_out(ms_out),
    .debug_mode_select_pin_oe_n(ms_oe_n), .periph_en(p_en),
    .periph_oe(p_oe), .periph_out(p_out), .gpio_in(pins),
    .gpio_pad(gpio_pad));
  rms_pod i_pod (.hold_rst(hold_rst), .hold_ms(hold_ms), .rst_out(rst_out),
    .rst_oe_n(rst_oe_n), .ms_out(ms_out), .ms_oe_n(ms_oe_n),
    .rst_pin(rst_pin), .ms_pin(ms_pin));

  task automatic end_sim;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  // bounded wait, sampled at rising edges
  task automatic wait_for(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 300) begin
      @(posedge hclk);
      k++;
    end
    if (s !== v) begin
      failures++;
      $display("mismatch at %0t: wait ran out", $time);
      end_sim;
    end
  endtask

  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    wait_for(hreadyout, 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge hclk);
    wait_for(hreadyout, 1'b1);
    rd = hrdata;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    n = 0;
    chk(rst_pin, 1'b0);
    while (rst_oe_n === 1'b0 && n < 100) begin
      @(posedge hclk);
      n++;
    end
    chk(n >= 33 && n <= 36, 32'h1);
    wait_for(core_reset_n, 1'b1);
    chk(debug_mode, 1'b0);
    chk({gpio_pad.oe_n, gpio_pad.pull_en}, 32'hFF00);
    rdchk(OFS_CAUSE, 32'h01);
    chk(hresp, 1'b0);
    rdchk(OFS_MODE, 32'h0);
    rdchk(8'h3C, 32'h0);
    rdchk(OFS_IRQ_STAT, 32'h1);
    xfer(1'b1, OFS_IRQ_MASK, 32'h1);
    rdchk(OFS_IRQ_MASK, 32'h1);
    chk(irq, 1'b1);
    xfer(1'b1, OFS_IRQ_STAT, 32'h1);
    rdchk(OFS_IRQ_STAT, 32'h0);
    chk(irq, 1'b0);
    xfer(1'b1, OFS_CTRL, 32'h2);
    rdchk(OFS_MODE, 32'h2);
    xfer(1'b1, OFS_GP_DATA, 32'hA5);
    xfer(1'b1, OFS_GP_DIR, 32'h0F);
    xfer(1'b1, OFS_GP_DRIVE, 32'h33);
    xfer(1'b1, OFS_GP_SLEW, 32'h55);
    xfer(1'b1, OFS_GP_PULL, 32'hFF);
    rdchk(OFS_GP_READ, 32'h35);
    chk({gpio_pad.oe_n, gpio_pad.pull_en}, 32'hF0F0);
    chk({gpio_pad.drive_hi[3:0], gpio_pad.slew_en[3:0]}, 32'h35);
    chk(gpio_pad.out, 32'hA5);
    p_en <= 8'hFF;
    p_oe <= 8'hFF;
    p_out <= 8'h5A;
    rdchk(OFS_GP_READ, 32'h35);
    chk({gpio_pad.oe_n, gpio_pad.out}, 32'h005A);
    p_en <= 8'h00;
    // a one is short low, a zero long low; sample at count ten
    for (int b = 1; b >= 0; b--) begin
      xfer(1'b1, OFS_BDC_TX, 32'(b));
      wait_for(ms_pin, 1'b0);
      n = 0;
      while (ms_pin === 1'b0 && n < 40) begin
        @(posedge hclk);
        n++;
      end
      chk(n, b ? BDC_ONE_LOW : BDC_ZERO_LOW);
      repeat (BDC_BIT_CYCLES) @(posedge hclk);
      rdchk(OFS_BDC_STAT, 32'(b * 2));
    end
    // bit done flag is sticky; clear it so the reset check sees only its own
    rdchk(OFS_IRQ_STAT, 32'h2);
    xfer(1'b1, OFS_IRQ_STAT, 32'h2);
    hold_ms <= 1'b1;
    hold_rst <= 1'b1;
    repeat (60) @(posedge hclk);
    chk({core_reset_n, clk_src_ext}, 32'h0);
    hold_rst <= 1'b0;
    wait_for(core_reset_n, 1'b1);
    hold_ms <= 1'b0;
    chk(debug_mode, 1'b1);
    rdchk(OFS_CAUSE, 32'h02);
    rdchk(OFS_IRQ_STAT, 32'h5);
    for (int k = 0; k < 5; k++) begin
      if (k == 0) xfer(1'b1, OFS_CTRL, 32'h1);
      else begin
        @(posedge hclk);
        int_rst_req <= 4'(1 << (k - 1));
        @(posedge hclk);
        int_rst_req <= 4'h0;
      end
      wait_for(core_reset_n, 1'b0);
      wait_for(core_reset_n, 1'b1);
      rdchk(OFS_CAUSE, 32'h04 << k);
    end
    end_sim;
  end

  initial begin
    repeat (100000) @(posedge hclk);
    failures++;
    $display("mismatch at %0t: run too long", $time);
    end_sim;
  end
endmodule // tb
